// file: include/pms_defines.svh
// Constants for the power multiply-accumulate sequencer
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

// Datapath widths
`define PMS_SAMPLE_W 12
`define PMS_OPND_W 16
`define PMS_PROD_W 32
`define PMS_ACC_W 35
`define PMS_ACC_HI_W 3

// Program memory shape and program entry points
`define PMS_ROM_AW 8
`define PMS_ROM_DEPTH 256
`define PMS_WORD_W 8
`define PMS_NORMAL_START 8'h5A
`define PMS_INTERVAL_START 8'h0A
`define PMS_ROM_FILL 8'h01

// Step timing: a least step time rounds up to whole cycles
`define PMS_CLK_NS 25
`define PMS_STEP_NS 70
`define PMS_STEP_CYC ((`PMS_STEP_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)
`define PMS_STEP_CW 2
`define PMS_STEP_LAST 2'(`PMS_STEP_CYC - 1)

// Fixed arithmetic controls
`define PMS_ACCUMULATE_SEL 1'b1
`define PMS_ROUND_SEL 1'b0
`define PMS_TWOS_COMP_SEL 1'b1

// Register byte offsets
`define PMS_REG_CTRL 8'h00
`define PMS_REG_STATUS 8'h04
`define PMS_REG_MASK 8'h08
`define PMS_REG_RES_LO 8'h0C
`define PMS_REG_RES_HI 8'h10
`define PMS_REG_SEQ 8'h14

// Register fields and reset values
`define PMS_CTRL_EN 0
`define PMS_ST_RESULT 0
`define PMS_ST_OVF 1
`define PMS_ST_W 2
`define PMS_CTRL_RST 32'h0000_0001
`define PMS_SEQ_ADDR_LSB 8

// Bus responses
`define PMS_RESP_OKAY 2'h0
`define PMS_RESP_SLVERR 2'h2

`endif

// file: include/pms_pkg.sv
// Types shared by the sequencer files
package pms_pkg;

  // One program word; field order matches the stored bit order, msb first
  typedef struct packed {
    logic low_part_buf_ctl;
    logic zero_preload;
    logic p_clk;
    logic xy_clk;
    logic strobe;
    logic y_clk;
    logic load_y;
    logic seq_reset;
  } pms_ctl_s;

  // Voltage and current converter words
  typedef struct packed {
    logic [11:0] volt;
    logic [11:0] curr;
  } pms_samples_s;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} pms_seq_e;

endpackage

// file: verilog/pms_prog_rom.sv
// Program memory of the microsequencer
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.svh"

module pms_prog_rom (
  input wire logic [`PMS_ROM_AW-1:0] addr,
  output pms_pkg::pms_ctl_s word
);
  import pms_pkg::*;

  logic [`PMS_WORD_W-1:0] rom_mem [0:`PMS_ROM_DEPTH-1];

  // Contents; unused words halt the sequencer so a stray address cannot run away
  always_comb begin
    for (int i = 0; i < `PMS_ROM_DEPTH; i++) begin
      rom_mem[i] = `PMS_ROM_FILL;
    end
    // End-of-interval program
    rom_mem[8'h0A] = 8'h00;
    rom_mem[8'h0B] = 8'h86;
    rom_mem[8'h0C] = 8'h92;
    rom_mem[8'h0D] = 8'h00;
    rom_mem[8'h0E] = 8'h20;
    rom_mem[8'h0F] = 8'h08;
    rom_mem[8'h10] = 8'hC0;
    rom_mem[8'h11] = 8'hE0;
    rom_mem[8'h12] = 8'h01;
    // Normal accumulate program
    rom_mem[8'h5A] = 8'h00;
    rom_mem[8'h5B] = 8'h86;
    rom_mem[8'h5C] = 8'h92;
    rom_mem[8'h5D] = 8'h00;
    rom_mem[8'h5E] = 8'h20;
    rom_mem[8'h5F] = 8'h01;
  end

  // Asynchronous read; the top samples the word at step boundaries
  assign word = rom_mem[addr];

endmodule
`default_nettype wire

// file: verilog/pms_mac_top.sv
// Sampling-wattmeter multiply-accumulate datapath with microsequencer and AXI4-Lite slave
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.svh"

module pms_mac_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic eoc_volt,
  input wire logic eoc_curr,
  input wire logic interval_end,
  input wire pms_pkg::pms_samples_s samples,
  output logic irq,
  output logic seq_busy,
  output pms_pkg::pms_ctl_s seq_ctl
);
  import pms_pkg::*;

  // Pin synchronisers: bit 0 volt end, bit 1 curr end, bit 2 interval end
  logic [2:0] sy1_r;
  logic [2:0] sy2_r;
  logic [2:0] sy3_r;
  logic [2:0] pin_r;
  logic [2:0] pin_d_r;
  logic [2:0] agree;
  logic eoc_volt_fall;
  logic eoc_curr_rise;

  // Sequencer state
  pms_seq_e state_r;
  logic volt_latch_r;
  logic curr_latch_r;
  logic mode_interval_r;
  logic [`PMS_ROM_AW-1:0] addr_r;
  logic [`PMS_STEP_CW-1:0] step_cnt_r;
  pms_ctl_s word;
  logic running;
  logic step_start;
  logic step_end;

  // Datapath registers
  logic [`PMS_OPND_W-1:0] x_operand_reg_r;
  logic [`PMS_OPND_W-1:0] y_operand_reg_r;
  logic [`PMS_OPND_W-1:0] holding_reg_r;
  logic [`PMS_ACC_W-1:0] accumulator_reg_r;
  logic [`PMS_ACC_W-1:0] result_out_reg_r;
  logic [`PMS_OPND_W-1:0] volt_wide;
  logic [`PMS_OPND_W-1:0] curr_wide;
  logic [`PMS_OPND_W-1:0] lower_product_bus;
  logic signed [`PMS_PROD_W-1:0] product;
  logic [`PMS_ACC_W-1:0] product_ext;
  logic [`PMS_ACC_W-1:0] acc_sum;
  logic acc_ovf;

  // Software registers
  logic [31:0] ctrl_r;
  logic [`PMS_ST_W-1:0] status_r;
  logic [`PMS_ST_W-1:0] mask_r;
  logic [`PMS_ST_W-1:0] st_set;
  logic [`PMS_ST_W-1:0] st_clr;

  // Bus slave state
  logic [7:0] aw_addr_r;
  logic aw_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_full_r;
  logic do_write;
  logic [31:0] wmask;
  logic enabled;

  assign enabled = ctrl_r[`PMS_CTRL_EN];

  // Three stages; a level counts once the second and third agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_r <= 3'h0;
      sy2_r <= 3'h0;
      sy3_r <= 3'h0;
    end else begin
      sy1_r <= {interval_end, eoc_curr, eoc_volt};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  assign agree = ~(sy2_r ^ sy3_r);

  // Filtered levels and their one-cycle history for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= 3'h0;
      pin_d_r <= 3'h0;
    end else begin
      pin_r <= (pin_r & ~agree) | (sy3_r & agree);
      pin_d_r <= pin_r;
    end
  end

  assign eoc_volt_fall = pin_d_r[0] & ~pin_r[0];
  assign eoc_curr_rise = pin_r[1] & ~pin_d_r[1];

  // Program memory
  pms_prog_rom pms_prog_rom_inst (
    .addr(addr_r),
    .word(word)
  );

  assign running = (state_r == SEQ_RUN);
  assign step_start = running && (step_cnt_r == `PMS_STEP_CW'(0));
  assign step_end = running && (step_cnt_r == `PMS_STEP_LAST);

  // Timing state: starts only once both converter latches are set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SEQ_IDLE;
    end else begin
      case (state_r)
        SEQ_IDLE: begin
          if (volt_latch_r && curr_latch_r) begin
            state_r <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (step_end && word.seq_reset) begin
            state_r <= SEQ_IDLE;
          end
        end
        default: begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Converter latches; edges during a running program are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      volt_latch_r <= 1'b0;
      curr_latch_r <= 1'b0;
    end else if (running) begin
      if (step_end && word.seq_reset) begin
        volt_latch_r <= 1'b0;
        curr_latch_r <= 1'b0;
      end
    end else if (enabled) begin
      if (eoc_volt_fall) begin
        volt_latch_r <= 1'b1;
      end
      if (eoc_curr_rise) begin
        curr_latch_r <= 1'b1;
      end
    end
  end

  // Address counter: preloaded by the volt trailing edge, stepped while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_r <= `PMS_NORMAL_START;
      mode_interval_r <= 1'b0;
    end else if (running) begin
      if (step_end && !word.seq_reset) begin
        addr_r <= addr_r + `PMS_ROM_AW'(1);
      end
    end else if (enabled && eoc_volt_fall) begin
      mode_interval_r <= pin_r[2];
      addr_r <= pin_r[2] ? `PMS_INTERVAL_START : `PMS_NORMAL_START;
    end
  end

  // Step timer; three cycles of 25 ns give a 75 ns step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt_r <= `PMS_STEP_CW'(0);
    end else if (step_end || !running) begin
      step_cnt_r <= `PMS_STEP_CW'(0);
    end else begin
      step_cnt_r <= step_cnt_r + `PMS_STEP_CW'(1);
    end
  end

  // Observable control word, one cycle behind the program word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_ctl <= '0;
      seq_busy <= 1'b0;
    end else begin
      seq_ctl <= running ? word : '0;
      seq_busy <= running;
    end
  end

  // Converter words are sign-extended onto the 16-bit operand paths
  assign volt_wide = {{(`PMS_OPND_W-`PMS_SAMPLE_W){samples.volt[`PMS_SAMPLE_W-1]}},
                      samples.volt};
  assign curr_wide = {{(`PMS_OPND_W-`PMS_SAMPLE_W){samples.curr[`PMS_SAMPLE_W-1]}},
                      samples.curr};

  // Low bus carries the holding register while its output buffer is off
  assign lower_product_bus = word.low_part_buf_ctl ? holding_reg_r : curr_wide;

  // Signed product, widened to the accumulator; truncation only, no round term
  assign product = $signed(x_operand_reg_r) * $signed(y_operand_reg_r);
  assign product_ext = {{(`PMS_ACC_W-`PMS_PROD_W){product[`PMS_PROD_W-1]}}, product};
  assign acc_sum = `PMS_ACCUMULATE_SEL ? accumulator_reg_r + product_ext : product_ext;
  assign acc_ovf = (accumulator_reg_r[`PMS_ACC_W-1] == product_ext[`PMS_ACC_W-1]) &&
                   (acc_sum[`PMS_ACC_W-1] != accumulator_reg_r[`PMS_ACC_W-1]);

  // Holding register: zeros on preload, the Y word on its capture clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      holding_reg_r <= `PMS_OPND_W'(0);
    end else if (step_start) begin
      if (word.zero_preload) begin
        holding_reg_r <= `PMS_OPND_W'(0);
      end else if (word.y_clk) begin
        holding_reg_r <= curr_wide;
      end
    end
  end

  // Operand registers, both taken on the operand clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_operand_reg_r <= `PMS_OPND_W'(0);
      y_operand_reg_r <= `PMS_OPND_W'(0);
    end else if (step_start && word.xy_clk) begin
      x_operand_reg_r <= volt_wide;
      y_operand_reg_r <= lower_product_bus;
    end
  end

  // Accumulator: sum of products, or the preloaded zeros when preload is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accumulator_reg_r <= `PMS_ACC_W'(0);
    end else if (step_start && word.p_clk) begin
      if (word.zero_preload) begin
        accumulator_reg_r <= {{(`PMS_ACC_W-`PMS_OPND_W){1'b0}}, holding_reg_r};
      end else begin
        accumulator_reg_r <= acc_sum;
      end
    end
  end

  // Result register follows the strobe; normal programs never touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_out_reg_r <= `PMS_ACC_W'(0);
    end else if (step_start && word.strobe) begin
      result_out_reg_r <= accumulator_reg_r;
    end
  end

  // Events: result ready when the strobe step ends, overflow on a wrapped sum
  always_comb begin
    st_set = '0;
    st_set[`PMS_ST_RESULT] = step_end && word.strobe;
    st_set[`PMS_ST_OVF] = step_start && word.p_clk && !word.zero_preload && acc_ovf;
  end

  // Write channel: address and data taken in either order, answered together
  assign do_write = aw_full_r && w_full_r && !bvalid;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_full_r <= 1'b1;
      aw_addr_r <= awaddr[7:0];
    end else begin
      if (do_write) begin
        aw_full_r <= 1'b0;
      end
      if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_full_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end else begin
      if (do_write) begin
        w_full_r <= 1'b0;
      end
      if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped or read-only words answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `PMS_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      case (aw_addr_r)
        `PMS_REG_CTRL, `PMS_REG_STATUS, `PMS_REG_MASK: begin
          bresp <= `PMS_RESP_OKAY;
        end
        default: begin
          bresp <= `PMS_RESP_SLVERR;
        end
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control and mask stores honour the byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `PMS_CTRL_RST;
      mask_r <= '0;
    end else if (do_write) begin
      if (aw_addr_r == `PMS_REG_CTRL) begin
        ctrl_r <= (ctrl_r & ~wmask) | (w_data_r & wmask);
      end
      if (aw_addr_r == `PMS_REG_MASK) begin
        mask_r <= (mask_r & ~wmask[`PMS_ST_W-1:0]) | (w_data_r[`PMS_ST_W-1:0] &
                  wmask[`PMS_ST_W-1:0]);
      end
    end
  end

  // Write-one-to-clear status; a new event in the clearing cycle is kept
  assign st_clr = (do_write && aw_addr_r == `PMS_REG_STATUS) ?
                  (w_data_r[`PMS_ST_W-1:0] & wmask[`PMS_ST_W-1:0]) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  // Read channel: one read at a time, data registered with the valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PMS_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `PMS_RESP_OKAY;
      case (araddr[7:0])
        `PMS_REG_CTRL: rdata <= ctrl_r;
        `PMS_REG_STATUS: rdata <= {{(32-`PMS_ST_W){1'b0}}, status_r};
        `PMS_REG_MASK: rdata <= {{(32-`PMS_ST_W){1'b0}}, mask_r};
        `PMS_REG_RES_LO: rdata <= result_out_reg_r[31:0];
        `PMS_REG_RES_HI: begin
          rdata <= {{(32-`PMS_ACC_HI_W){result_out_reg_r[`PMS_ACC_W-1]}},
                    result_out_reg_r[`PMS_ACC_W-1:32]};
        end
        `PMS_REG_SEQ: begin
          rdata <= {16'h0000, addr_r, 4'h0, mode_interval_r, curr_latch_r,
                    volt_latch_r, running};
        end
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `PMS_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: sim/pms_mac_monitor.sv
// Checker for bus answers and program stepping of the sequencer top
`timescale 1ns/100ps
`default_nettype none
module pms_mac_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic seq_busy,
  input wire pms_pkg::pms_ctl_s seq_ctl
);
  import pms_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus write handshake and multi-step pieces of the programs
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_ycap;
    $rose(seq_ctl.y_clk) && seq_ctl.low_part_buf_ctl;
  endsequence
  sequence s_mac_tail;
    ##3 (seq_ctl.xy_clk && seq_ctl.low_part_buf_ctl) ##6 seq_ctl.p_clk;
  endsequence
  sequence s_zero_tail;
    ##3 (seq_ctl.p_clk && seq_ctl.zero_preload) ##3 seq_ctl.seq_reset;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
    else $error("write answer late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_busy_bound: assert property ($rose(seq_busy) |-> ##[18:27] $fell(seq_busy))
    else $error("program length wrong");
  a_step_hold: assert property ($rose(seq_busy) |=> $stable(seq_ctl)[*2])
    else $error("step shorter than three cycles");
  a_ycap_tail: assert property (s_ycap |-> s_mac_tail)
    else $error("capture and product order wrong");
  a_y_via_hold: assert property (seq_ctl.xy_clk |-> seq_ctl.load_y && seq_ctl.low_part_buf_ctl)
    else $error("y not routed through holding register");
  a_preload_zero: assert property ($rose(seq_ctl.zero_preload) |-> s_zero_tail)
    else $error("zero preload order wrong");
  a_strobe_clear: assert property ($rose(seq_ctl.strobe) |-> $past(seq_ctl.p_clk, 3) ##3 seq_ctl.zero_preload)
    else $error("strobe not between product and clear");
  a_reset_end: assert property (seq_ctl.seq_reset |-> ##[1:3] !seq_busy)
    else $error("reset word did not stop program");
  a_idle_quiet: assert property (!seq_busy |-> seq_ctl == 8'h00)
    else $error("controls active while idle");
endmodule
bind pms_mac_top pms_mac_monitor pms_mac_monitor_inst (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .seq_busy(seq_busy), .seq_ctl(seq_ctl));
`default_nettype wire

// file: sim/pms_adc_model.sv
// Behavioural pair of voltage and current converters
`timescale 1ns/100ps
`default_nettype none
module pms_adc_model (
  input wire logic aclk,
  input wire logic seq_busy,
  output var logic eoc_volt,
  output var logic eoc_curr,
  output pms_pkg::pms_samples_s samples
);
  import pms_pkg::*;
  initial begin
    eoc_volt = 1'b0;
    eoc_curr = 1'b0;
    samples = 24'h5A5A5A;
  end
  // One pair; gap below six puts the current edge before the voltage trailing edge
  task automatic convert(input logic [11:0] v, input logic [11:0] c, input int gap);
    int n;
    n = 0;
    @(posedge aclk);
    samples <= '{volt: v, curr: c};
    eoc_volt <= 1'b1;
    if (gap < 6) begin
      repeat (gap) @(posedge aclk);
      eoc_curr <= 1'b1;
      repeat (6 - gap) @(posedge aclk);
      eoc_volt <= 1'b0;
    end else begin
      repeat (6) @(posedge aclk);
      eoc_volt <= 1'b0;
      repeat (gap - 6) @(posedge aclk);
      eoc_curr <= 1'b1;
    end
    while (seq_busy !== 1'b1 && n < 40) @(posedge aclk) n++;
    while (seq_busy === 1'b1 && n < 90) @(posedge aclk) n++;
    // Hold time over: words no longer show the last value
    samples <= ~samples;
    eoc_curr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: sim/power_mac_sequencer_tb.sv
// Self-checking bench for the multiply-accumulate sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.svh"
module power_mac_sequencer_tb;
  import pms_pkg::*;
  typedef struct {logic [11:0] v0, c0, v1, c1; int gap; logic [34:0] sum;} pms_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, interval_end = 0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, seq_busy, eoc_volt, eoc_curr;
  logic [1:0] bresp, rresp, resp;
  int busy_cnt = 0;
  int busy_mark;
  pms_samples_s samples;
  pms_ctl_s seq_ctl;
  int num_errors = 0;
  int checked = 0;
  // Program words: normal at 0..5, end of interval at 6..14
  logic [7:0] prog [15] = '{8'h00, 8'h86, 8'h92, 8'h00, 8'h20, 8'h01,
    8'h00, 8'h86, 8'h92, 8'h00, 8'h20, 8'h08, 8'hC0, 8'hE0, 8'h01};
  // One interval a row, two pairs each, far inside the overflow limit
  pms_row_s rows [3] = '{'{12'h7FF, 12'h7FF, 12'h800, 12'h7FF, 2, 35'h7FFFFF801},
    '{12'h800, 12'h800, 12'h800, 12'h800, 12, 35'h000800000},
    '{12'h001, 12'hFFF, 12'h123, 12'h456, 5, 35'h00004EDC1}};
  always #12.5 aclk = ~aclk;
  // Counts cycles with a program running; one driver, sampled around a test
  always @(posedge aclk) if (seq_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  pms_mac_top pms_mac_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .eoc_volt(eoc_volt), .eoc_curr(eoc_curr),
    .interval_end(interval_end), .samples(samples), .irq(irq), .seq_busy(seq_busy),
    .seq_ctl(seq_ctl));
  pms_adc_model pms_adc_model_inst (.aclk(aclk), .seq_busy(seq_busy),
    .eoc_volt(eoc_volt), .eoc_curr(eoc_curr), .samples(samples));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Compares each step's word at its first cycle, then the end of busy
  task automatic watch(input int base, input int len);
    int n;
    n = 0;
    while (seq_busy !== 1'b1 && n < 60) @(posedge aclk) #1 n++;
    chk("seq_busy_start", 1'b1, seq_busy);
    for (int k = 0; k < len; k++) begin
      chk("seq_ctl", prog[base+k], seq_ctl);
      repeat (3) @(posedge aclk);
      #1;
    end
    chk("seq_busy_end", 1'b0, seq_busy);
  endtask
  task automatic run_pair(input logic [11:0] v, input logic [11:0] c, input int gap,
    input logic ie);
    interval_end <= ie;
    fork
      pms_adc_model_inst.convert(v, c, gap);
      watch(ie ? 6 : 0, ie ? 9 : 6);
    join
    @(posedge aclk);
    interval_end <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (8000) @(posedge aclk);
    num_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`PMS_REG_CTRL);
    chk("ctrl_reset", 32'h1, rd);
    axi_rd(`PMS_REG_STATUS);
    chk("status_reset", 32'h0, rd);
    axi_rd(`PMS_REG_SEQ);
    chk("seq_reset", 32'h00005A00, rd);
    $display("test reset done");
    // Sum restarts from zero each row, so rows also show clearing
    foreach (rows[i]) begin
      run_pair(rows[i].v0, rows[i].c0, rows[i].gap, 1'b0);
      run_pair(rows[i].v1, rows[i].c1, rows[i].gap, 1'b1);
      axi_rd(`PMS_REG_RES_LO);
      chk("result_lo", rows[i].sum[31:0], rd);
      axi_rd(`PMS_REG_RES_HI);
      chk("result_hi", {{29{rows[i].sum[34]}}, rows[i].sum[34:32]}, rd);
      chk("irq_masked", 1'b0, irq);
      $display("test row %0d done", i);
    end
    // Sticky ready flag, mask and write-one clear
    axi_rd(`PMS_REG_STATUS);
    chk("status_ready", 1'b1, rd[0]);
    axi_wr(`PMS_REG_MASK, 32'h1);
    chk("mask_resp", `PMS_RESP_OKAY, resp);
    repeat (3) @(posedge aclk);
    chk("irq_on", 1'b1, irq);
    axi_wr(`PMS_REG_STATUS, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq_cleared", 1'b0, irq);
    run_pair(12'h7FF, 12'h800, 3, 1'b1);
    chk("irq_strobe", 1'b1, irq);
    axi_rd(`PMS_REG_RES_LO);
    chk("result_fresh", 32'hFFC00800, rd);
    axi_wr(`PMS_REG_STATUS, 32'h1);
    $display("test interrupt done");
    // Converter edges ignored while disabled
    axi_wr(`PMS_REG_CTRL, 32'h0);
    busy_mark = busy_cnt;
    pms_adc_model_inst.convert(12'h100, 12'h100, 2);
    chk("busy_when_off", busy_mark, busy_cnt);
    axi_wr(`PMS_REG_CTRL, 32'h1);
    $display("test disable done");
    // Unmapped and read-only places
    axi_rd(8'h40);
    chk("unmapped_rresp", `PMS_RESP_SLVERR, resp);
    chk("unmapped_rdata", 32'h0, rd);
    axi_wr(8'h40, 32'hFFFFFFFF);
    chk("unmapped_bresp", `PMS_RESP_SLVERR, resp);
    axi_wr(`PMS_REG_RES_LO, 32'h0);
    chk("ro_bresp", `PMS_RESP_SLVERR, resp);
    axi_rd(`PMS_REG_RES_LO);
    chk("ro_kept", 32'hFFC00800, rd);
    $display("test bus errors done");
    print_verdict();
  end
endmodule
`default_nettype wire
